//--- logic/twra_slave.sv
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - every byte moves msb first, lsb last
// - one address bit must equal the sampled strap level
// - low index nibble increments after each data byte
// - upper index nibble never takes a carry
// - all registers take reset values at power-on reset
// - device acks master bytes; master acks device read data
module twra_slave
    import twra_pkg::*;
#(
    parameter int REG_COUNT = TWRA_REG_COUNT
) (
    // clock and power-on reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // serial bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output var  logic       sda_out,
    output var  logic       sda_oe_n,
    // strap
    input  wire logic       address_select_strap,
    // register index and write strobe with data to the rest of the chip
    output var  logic [7:0] reg_index,
    output var  logic       reg_write_pulse,
    output var  logic [7:0] reg_write_data
);

    ////////////////////////////////////////////////////////////////////////////
    // synchronisers

    logic scl_s;
    logic sda_s;
    logic strap_s;
    logic scl_d;
    logic sda_d;

    twra_sync #(.RESET_VALUE(1'b1)) u_scl (
        .clk  (clk),
        .nrst (nrst),
        .din  (scl_in),
        .dout (scl_s)
    );

    twra_sync #(.RESET_VALUE(1'b1)) u_sda (
        .clk  (clk),
        .nrst (nrst),
        .din  (sda_in),
        .dout (sda_s)
    );

    twra_sync #(.RESET_VALUE(1'b0)) u_strap (
        .clk  (clk),
        .nrst (nrst),
        .din  (address_select_strap),
        .dout (strap_s)
    );

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    assign scl_rise   = scl_s & ~scl_d;
    assign scl_fall   = ~scl_s & scl_d;
    assign start_cond = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_cond  = scl_s & scl_d & ~sda_d & sda_s;

    ////////////////////////////////////////////////////////////////////////////
    // strap level, followed every cycle: the synchroniser still shows
    // its reset value on the first edges after release

    logic strap_level;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            strap_level <= 1'b0;
        end else begin
            strap_level <= strap_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bit engine and state

    twra_state_type state;
    logic [3:0]     bit_cnt;
    logic [7:0]     shift;
    logic           is_read;
    logic [7:0]     regs [REG_COUNT];
    logic [6:0]     my_addr;
    logic [7:0]     rd_byte;

    always_comb begin
        my_addr                 = TWRA_DEV_ADDR_BASE;
        my_addr[TWRA_STRAP_BIT] = strap_level;
    end

    // out-of-range indices read zero; no wider map exists
    assign rd_byte = (int'(reg_index) < REG_COUNT) ? regs[reg_index[5:0]] : 8'h00;

    // next index: low nibble wraps, upper held
    logic [7:0] next_index;
    assign next_index = {reg_index[7:4], reg_index[3:0] + 4'h1};

    logic byte_done;
    assign byte_done = scl_rise && (bit_cnt == TWRA_BITS_PER_BYTE - 4'h1);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state           <= TWRA_IDLE;
            bit_cnt         <= TWRA_BIT_CNT_RESET;
            shift           <= 8'h00;
            is_read         <= 1'b0;
            reg_index       <= TWRA_INDEX_RESET;
            reg_write_pulse <= 1'b0;
            reg_write_data  <= 8'h00;
        end else begin
            reg_write_pulse <= 1'b0;
            if (stop_cond) begin
                state <= TWRA_IDLE;
            end else if (start_cond) begin
                // repeated start also lands here
                state   <= TWRA_ADDR;
                bit_cnt <= TWRA_BIT_CNT_RESET;
            end else begin
                case (state)
                    TWRA_ADDR, TWRA_INDEX, TWRA_WDATA: begin
                        if (scl_rise) begin
                            shift   <= {shift[6:0], sda_s};
                            bit_cnt <= bit_cnt + 4'h1;
                        end
                        if (byte_done) begin
                            bit_cnt <= TWRA_BIT_CNT_RESET;
                            case (state)
                                TWRA_ADDR: begin
                                    if (shift[6:0] == my_addr) begin
                                        is_read <= (sda_s == TWRA_DIR_READ);
                                        state   <= TWRA_ADDR_ACK;
                                    end else begin
                                        state <= TWRA_IDLE;
                                    end
                                end
                                TWRA_INDEX: begin
                                    reg_index <= {shift[6:0], sda_s};
                                    state     <= TWRA_WACK;
                                end
                                default: begin
                                    reg_write_data  <= {shift[6:0], sda_s};
                                    reg_write_pulse <= 1'b1;
                                    state           <= TWRA_WACK;
                                end
                            endcase
                        end
                    end
                    TWRA_ADDR_ACK: begin
                        if (scl_fall && bit_cnt == 4'h1) begin
                            bit_cnt <= TWRA_BIT_CNT_RESET;
                            shift   <= rd_byte;
                            state   <= is_read ? TWRA_RDATA : TWRA_INDEX;
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h1;
                        end
                    end
                    TWRA_WACK: begin
                        // index steps once per stored data byte, never after the index byte
                        if (reg_write_pulse) begin
                            reg_index <= next_index;
                        end
                        // ack pulse ends on the second falling edge
                        if (scl_fall && bit_cnt == 4'h1) begin
                            bit_cnt <= TWRA_BIT_CNT_RESET;
                            state   <= TWRA_WDATA;
                        end else if (scl_fall) begin
                            bit_cnt <= 4'h1;
                        end
                    end
                    TWRA_RDATA: begin
                        if (scl_rise) begin
                            bit_cnt <= bit_cnt + 4'h1;
                        end else if (scl_fall && bit_cnt == TWRA_BITS_PER_BYTE) begin
                            // bit 0 stays on the line until scl is low again,
                            // releasing it while scl is high would look like a stop
                            bit_cnt   <= TWRA_BIT_CNT_RESET;
                            reg_index <= next_index;
                            state     <= TWRA_RACK;
                        end else if (scl_fall && bit_cnt != TWRA_BIT_CNT_RESET) begin
                            shift <= {shift[6:0], 1'b0};
                        end
                    end
                    TWRA_RACK: begin
                        if (scl_rise) begin
                            // master ack low continues, nack ends the read
                            state <= sda_s ? TWRA_IDLE : TWRA_RACK;
                        end else if (scl_fall && scl_d) begin
                            shift <= rd_byte;
                            state <= TWRA_RDATA;
                        end
                    end
                    default: state <= TWRA_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // register storage; write index advances after each stored byte

    logic wr_advance;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_advance <= 1'b0;
        end else begin
            wr_advance <= reg_write_pulse;
        end
    end

    // index update on writes kept apart from the state process
    logic [7:0] wr_index;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_index <= TWRA_INDEX_RESET;
        end else if (state == TWRA_INDEX || state == TWRA_ADDR) begin
            wr_index <= {shift[6:0], sda_s};
        end else if (wr_advance) begin
            wr_index <= {wr_index[7:4], wr_index[3:0] + 4'h1};
        end
    end

    genvar g;
    generate
        for (g = 0; g < REG_COUNT; g++) begin : g_reg
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    regs[g] <= TWRA_REG_RESET;
                end else if (reg_write_pulse && int'(wr_index) == g) begin
                    regs[g] <= reg_write_data;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // sda drive: open drain, oe low means pulling or driving

    logic ack_low;
    logic data_low;

    assign ack_low  = (state == TWRA_ADDR_ACK || state == TWRA_WACK) &&
                      !(scl_fall && bit_cnt == 4'h1);
    assign data_low = (state == TWRA_RDATA) && !shift[7];

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sda_out  <= 1'b1;
            sda_oe_n <= 1'b1;
        end else begin
            sda_out  <= 1'b0;
            sda_oe_n <= !((ack_low && bit_cnt == 4'h1) || data_low);
        end
    end

endmodule

`default_nettype wire

//--- logic/twra_sync.sv
`timescale 1ns/100ps
`default_nettype none

module twra_sync #(
    parameter logic RESET_VALUE = 1'b1
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // async level in, synchronised level out
    input  wire logic din,
    output var  logic dout
);

    logic stage1;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stage1 <= RESET_VALUE;
            dout   <= RESET_VALUE;
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end

endmodule

`default_nettype wire

//--- shared/twra_pkg.sv
package twra_pkg;

    // seven-bit device address; the strap supplies bit 0
    localparam logic [6:0] TWRA_DEV_ADDR_BASE = 7'h4c;
    localparam int         TWRA_STRAP_BIT     = 0;

    // register space and reset values
    localparam int         TWRA_REG_COUNT     = 64;
    localparam logic [7:0] TWRA_REG_RESET     = 8'h00;
    localparam logic [7:0] TWRA_INDEX_RESET   = 8'h00;

    // direction bit encoding
    localparam logic       TWRA_DIR_READ      = 1'b1;
    localparam logic       TWRA_DIR_WRITE     = 1'b0;

    // bit counter
    localparam logic [3:0] TWRA_BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] TWRA_BIT_CNT_RESET = 4'h0;

    typedef enum logic [2:0] {
        TWRA_IDLE,
        TWRA_ADDR,
        TWRA_ADDR_ACK,
        TWRA_INDEX,
        TWRA_WDATA,
        TWRA_WACK,
        TWRA_RDATA,
        TWRA_RACK
    } twra_state_type;

endpackage

//--- tb/twra_bus_master.sv
`timescale 1ns/100ps
`default_nettype none

module twra_bus_master (
    // open-drain lines, pulled up when released
    output var  logic scl,
    output var  logic sda_drv,
    input  wire logic sda
);
    // quarter of the 125 ns bit time
    localparam realtime Q = 31.25;

    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end

    task automatic start();
        sda_drv = 1'b1;
        scl = 1'b1;
        #Q;
        sda_drv = 1'b0;
        #Q;
        scl = 1'b0;
        #Q;
    endtask

    task automatic stop();
        sda_drv = 1'b0;
        #Q;
        scl = 1'b1;
        #Q;
        sda_drv = 1'b1;
        #Q;
    endtask

    task automatic wbit(input logic b);
        sda_drv = b;
        #Q;
        scl = 1'b1;
        #(2 * Q);
        scl = 1'b0;
        #Q;
    endtask

    task automatic rbit(output logic v);
        sda_drv = 1'b1;
        #Q;
        scl = 1'b1;
        #Q;
        v = sda;
        #Q;
        scl = 1'b0;
        #Q;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic nak);
        for (int i = 7; i >= 0; i--) wbit(d[i]);
        rbit(nak);
    endtask

    task automatic rbyte(output logic [7:0] d, input logic mack);
        for (int i = 7; i >= 0; i--) rbit(d[i]);
        wbit(mack);
    endtask
endmodule

`default_nettype wire

//--- tb/twra_slave_props.sv
`timescale 1ns/100ps
`default_nettype none

module twra_slave_props
    import twra_pkg::*;
#(
    parameter int REG_COUNT = TWRA_REG_COUNT
) (
    // clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // bus pins and strap
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_n,
    input wire logic       address_select_strap,
    // register side
    input wire logic [7:0] reg_index,
    input wire logic       reg_write_pulse,
    input wire logic [7:0] reg_write_data
);
    // expected low nibble once the data byte is done
    logic [3:0] inc_lo;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            inc_lo <= 4'h0;
        end else if (reg_write_pulse) begin
            inc_lo <= reg_index[3:0] + 4'h1;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    a_drive_low: assert property (!sda_oe_n |-> !sda_out)
        else $error("sda driven high");
    a_sda_while_low: assert property ($changed(sda_oe_n) |-> !scl_in)
        else $error("sda moved while scl high");
    a_ack_held: assert property ($rose(scl_in) && !sda_oe_n |=> !sda_oe_n [*8])
        else $error("driven bit dropped early");
    a_pulse_single: assert property (reg_write_pulse |=> !reg_write_pulse [*8])
        else $error("write pulse too long");
    a_ack_after_write: assert property (reg_write_pulse |-> ##[1:40] !sda_oe_n)
        else $error("written byte not acked");
    a_upper_kept: assert property (reg_write_pulse |=> reg_index[7:4] == $past(reg_index[7:4]))
        else $error("upper nibble changed");
    a_low_step: assert property (reg_write_pulse |=> ##[0:60] reg_index[3:0] == inc_lo)
        else $error("low nibble did not step");
    a_reset_vals: assert property ($rose(nrst) |-> reg_index == TWRA_INDEX_RESET && sda_oe_n)
        else $error("bad state after reset");
endmodule

`default_nettype wire

//--- tb/twra_slave_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module twra_slave_tb_top
    import twra_pkg::*;
;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       strap = 1'b1;
    logic       scl;
    logic       sda_m;
    logic       sda_out;
    logic       sda_oe_n;
    logic       pulse;
    logic [7:0] idx;
    logic [7:0] wdata;
    logic [7:0] d [4];
    logic [7:0] wq [$];
    logic [31:0] rs = 32'h2f;
    logic       ack;
    int         err_total = 0;
    int         cmp_count = 0;
    // wired-and of both parties on the data line
    wire logic  sda = sda_m & (sda_oe_n | sda_out);

    always #2 clk = ~clk;

    twra_slave uut (.clk(clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .address_select_strap(strap), .reg_index(idx),
        .reg_write_pulse(pulse), .reg_write_data(wdata));
    twra_bus_master mst (.scl(scl), .sda_drv(sda_m), .sda(sda));

    // sampled off the launching edge
    always @(negedge clk) if (pulse === 1'b1) wq.push_back(wdata);

    function automatic logic [7:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs[7:0];
    endfunction

    function automatic logic [7:0] dev(input logic s, input logic dir);
        return {TWRA_DEV_ADDR_BASE[6:1], s, dir};
    endfunction

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic rst(input logic s);
        @(posedge clk);
        nrst <= 1'b0;
        strap <= s;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
    endtask

    // one transfer per sixteen-register group, never across it
    task automatic rd(input logic [7:0] ix, input int n, input logic [7:0] e0, e1, e2);
        logic [7:0] e [3];
        logic [7:0] got;
        e = '{e0, e1, e2};
        mst.start();
        mst.wbyte(dev(strap, TWRA_DIR_WRITE), ack);
        mst.wbyte(ix, ack);
        mst.stop();
        mst.start();
        mst.wbyte(dev(strap, TWRA_DIR_READ), ack);
        chk("read ack", 8'h0, {7'h0, ack});
        for (int j = 0; j < n; j++) begin
            mst.rbyte(got, j == n - 1);
            chk("read data", e[j], got);
        end
        mst.stop();
    endtask

    initial begin
        #400000;
        err_total++;
        close_out();
    end

    initial begin
        rst(1'b1);
        chk("reset index", TWRA_INDEX_RESET, idx);
        mst.start();
        mst.wbyte(dev(1'b0, TWRA_DIR_WRITE), ack);
        mst.stop();
        chk("foreign ack", 8'h1, {7'h0, ack});
        mst.start();
        mst.wbyte(dev(1'b1, TWRA_DIR_WRITE), ack);
        chk("write ack", 8'h0, {7'h0, ack});
        mst.wbyte(8'h2e, ack);
        for (int i = 0; i < 4; i++) begin
            d[i] = rnd();
            mst.wbyte(d[i], ack);
            chk("data ack", 8'h0, {7'h0, ack});
        end
        mst.stop();
        chk("write count", 8'h4, 8'(wq.size()));
        if (wq.size() == 4) for (int i = 0; i < 4; i++) chk("wdata", d[i], wq[i]);
        chk("wrapped index", 8'h22, idx);
        rd(8'h2f, 3, d[1], d[2], d[3]);
        rd(8'h05, 1, TWRA_REG_RESET, 8'h0, 8'h0);
        rst(1'b0);
        mst.start();
        mst.wbyte(dev(1'b0, TWRA_DIR_WRITE), ack);
        chk("strap low ack", 8'h0, {7'h0, ack});
        mst.wbyte(8'h10, ack);
        mst.stop();
        chk("index set", 8'h10, idx);
        rd(8'h2f, 1, TWRA_REG_RESET, 8'h0, 8'h0);
        close_out();
    end
endmodule

bind twra_slave twra_slave_props #(.REG_COUNT(REG_COUNT)) props (.clk(clk), .nrst(nrst),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .address_select_strap(address_select_strap), .reg_index(reg_index),
    .reg_write_pulse(reg_write_pulse), .reg_write_data(reg_write_data));

`default_nettype wire
